/* File: common/card_pkg.sv */
// constants, state and carrier types of the card data-token link
// assumes a bit-serial link clocked by the host and a core clock for status
package card_pkg;

   // block length limits and counter width
   localparam int BLK_LEN_DEF = 512;
   localparam int BLK_LEN_MIN = 2;
   localparam int BLK_LEN_MAX = 4096;
   localparam int CNT_W       = 13;

   // token and filler bytes
   localparam logic [7:0] TOK_START       = 8'hFE;
   localparam logic [7:0] TOK_START_MULTI = 8'hFC;
   localparam logic [7:0] TOK_HALT        = 8'hFD;
   localparam logic [7:0] BYTE_IDLE       = 8'hFF;
   localparam logic [7:0] BYTE_BUSY       = 8'h00;
   localparam logic [2:0] BIT_LAST        = 3'h7;

   // write-acknowledge status codes and padding
   localparam logic [2:0] ACK_ACCEPT  = 3'h2;
   localparam logic [2:0] ACK_CRC_BAD = 3'h5;
   localparam logic [2:0] ACK_WR_FAIL = 3'h6;
   localparam logic [2:0] ACK_PAD     = 3'h7;
   localparam logic [3:0] FAIL_PAD    = 4'h0;

   // data crc
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [15:0] CRC_INIT = 16'h0000;

   // sync slots, link to core and core to link
   localparam int SY_WR   = 0;
   localparam int SY_BLK  = 1;
   localparam int SY_HALT = 2;
   localparam int SY_REQ  = 3;
   localparam int SY_TOK  = 4;
   localparam int LS_RD    = 0;
   localparam int LS_BUSY  = 1;
   localparam int LS_WFAIL = 2;

   typedef enum logic [2:0] {
      L_IDLE     = 3'h0,
      L_RX_DATA  = 3'h1,
      L_RX_CRC   = 3'h3,
      L_TX_ACK   = 3'h2,
      L_TX_START = 3'h6,
      L_TX_DATA  = 3'h7,
      L_TX_CRC   = 3'h5,
      L_TX_ERR   = 3'h4
   } link_state_e;

   // short command response byte, top bit always zero
   typedef struct packed {
      logic zero;
      logic param_err;
      logic addr_err;
      logic erase_seq_err;
      logic cmd_crc_err;
      logic illegal_cmd;
      logic erase_reset;
      logic idle;
   } short_resp_s;

   // second byte of the long status response
   typedef struct packed {
      logic out_of_range_ovw;
      logic erase_param;
      logic wp_violation;
      logic ecc_failed;
      logic controller_fault_flag;
      logic gen_error;
      logic erase_skip_lock_fail;
      logic locked;
   } status_ext_s;

   // bits that survive a read, and bits carried by the read-failure token
   localparam logic [7:0] SR_KEEP   = 8'h01;
   localparam logic [7:0] EXT_KEEP  = 8'h01;
   localparam logic [7:0] FAIL_MASK = 8'h9C;

   // one-cycle event pulses that set error and state flags
   typedef struct packed {
      logic illegal_cmd;
      logic cmd_crc_err;
      logic erase_seq_err;
      logic addr_err;
      logic param_err;
      logic erase_reset;
      logic out_of_range;
      logic csd_overwrite;
      logic erase_param;
      logic wp_violation;
      logic ecc_failed;
      logic controller_fault_flag;
      logic gen_error;
      logic erase_skip;
      logic lock_fail;
   } flag_evt_s;

   typedef struct packed {
      logic [4:0]  s1;
      logic [4:0]  s2;
      logic [4:0]  s3;
      logic        rd_tgl;
      logic        rd_fail_hold;
      status_ext_s snap;
      logic [7:0]  rd_hold;
      logic [7:0]  wr_byte;
      logic        wr_valid;
      logic        blk_done;
      logic        blk_ok;
      logic        halt;
      logic        rd_req;
      short_resp_s sr;
      status_ext_s ext;
   } core_s;

   typedef struct packed {
      logic [1:0]       rst_sy;
      logic [2:0]       i1;
      logic [2:0]       i2;
      link_state_e      st;
      logic [2:0]       bit_cnt;
      logic [CNT_W-1:0] cnt;
      logic [6:0]       rx_sh;
      logic [7:0]       tx;
      logic [7:0]       wr_hold;
      logic             t_wr;
      logic             t_blk;
      logic             t_halt;
      logic             t_req;
      logic             t_tok;
      logic             blk_ok;
      logic             rd_seen;
   } link_s;

   typedef struct packed {
      logic [15:0] crc;
   } crc_s;

   function automatic logic [7:0] fail_token(input status_ext_s s);
      return {FAIL_PAD, s.out_of_range_ovw, s.ecc_failed, s.controller_fault_flag, s.gen_error};
   endfunction : fail_token

endpackage : card_pkg

/* File: dv/host_link_model.sv */
// host end of the card data link: serial clock, select and host data
// assumes card data changes on the rising edge; it is sampled just before the next one
`timescale 1ns/10ps
module host_link_model (
   // serial link
   output logic      link_clk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   initial begin
      link_clk = 1'b0;
      cs_n     = 1'b1;
      mosi     = 1'b1;
   end

   // one bit; clock stands still between calls
   task automatic pulse(input logic b, output logic r);
      mosi = b;
      #62.5 r = miso;
      link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
   endtask : pulse

   // one byte each way, msb first
   task automatic xfer(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         pulse(t[i], r[i]);
      end
   endtask : xfer

   // data line flips to the inverse of its last value at every select change
   task automatic sel(input logic on);
      cs_n = ~on;
      mosi = ~mosi;
   endtask : sel

   // deselected clocks, for the reset of the link side
   task automatic idle_clk(input int n);
      logic r;
      repeat (n) pulse(1'b1, r);
   endtask : idle_clk
endmodule : host_link_model

/* File: dv/tb_card_data_link.sv */
// self-checking bench of the card data link with a host model on the serial side
// assumes a block length of 4 and a pull-up on the card data line
`timescale 1ns/10ps
module tb_card_data_link;
   import card_pkg::*;
   logic mclk, rst_n, link_clk, cs_n, mosi, miso_o, miso_oe_n, rd_start, rd_fail, rd_byte_req;
   logic wr_byte_valid, wr_blk_done, wr_blk_crc_ok, wr_halt, wr_fail, busy, reset_cmd;
   logic init_done, locked_in, short_rd, long_rd, halt_seen;
   logic [7:0] rd_byte, wr_byte, rx;
   logic [15:0] long_resp;
   short_resp_s short_resp;
   flag_evt_s evt;
   int mismatches, samples_checked, idx, n_wr, n_blk;
   logic [7:0] blk [4] = '{8'hA5, 8'h3C, 8'h00, 8'hFF};
   wire miso = miso_oe_n ? 1'b1 : miso_o;

   card_data_link #(.BLK_LEN(4)) u_card_data_link (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
      .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o), .miso_oe_n(miso_oe_n), .rd_start(rd_start),
      .rd_fail(rd_fail), .rd_byte(rd_byte), .rd_byte_req(rd_byte_req), .wr_byte(wr_byte),
      .wr_byte_valid(wr_byte_valid), .wr_blk_done(wr_blk_done), .wr_blk_crc_ok(wr_blk_crc_ok),
      .wr_halt(wr_halt), .wr_fail(wr_fail), .busy(busy), .evt(evt), .reset_cmd(reset_cmd),
      .init_done(init_done), .locked_in(locked_in), .short_rd(short_rd), .long_rd(long_rd),
      .short_resp(short_resp), .long_resp(long_resp));
   host_link_model u_host_link_model (.link_clk(link_clk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (wr_halt === 1'b1) halt_seen <= 1'b1;
   // payload byte and block strobes seen on the core side
   always @(posedge mclk) {n_wr, n_blk} <= {n_wr + (wr_byte_valid === 1'b1), n_blk + (wr_blk_done === 1'b1)};
   always @(negedge mclk) if (rd_byte_req === 1'b1) begin
      rd_byte = blk[idx[1:0]];
      idx++;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   function automatic logic [15:0] crc16();
      logic [15:0] c = 16'h0000;
      foreach (blk[i]) for (int b = 7; b >= 0; b--) c = {c[14:0], 1'b0} ^ ((c[15] ^ blk[i][b]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction : crc16

   task automatic xb(input logic [7:0] t);
      u_host_link_model.xfer(t, rx);
   endtask : xb

   task automatic pulse_in(ref logic s);
      @(negedge mclk) s = 1'b1;
      @(negedge mclk) s = 1'b0;
      @(negedge mclk);
   endtask : pulse_in

   task automatic flags;
      @(negedge mclk) evt = 15'h2A82;
      locked_in = 1'b1;
      @(negedge mclk) evt = '0;
      @(negedge mclk) check(long_resp, 16'h2B83);
      pulse_in(short_rd);
      check(long_resp, 16'h0183);
      pulse_in(long_rd);
      check(long_resp, 16'h0101);
      pulse_in(init_done);
      check(long_resp, 16'h0001);
      pulse_in(reset_cmd);
      check(long_resp, 16'h0101);
      locked_in = 1'b0;
      pulse_in(init_done);
      check(long_resp, 16'h0000);
      @(negedge mclk) {evt.addr_err, short_rd} = 2'h3;
      @(negedge mclk) {evt.addr_err, short_rd} = 2'h0;
      @(negedge mclk) check(long_resp, 16'h2000);
      check(short_resp, 16'h0020);
      pulse_in(short_rd);
      check(long_resp, 16'h0000);
   endtask : flags

   task automatic wr_blk(input logic [7:0] tok, input logic [15:0] flip, input logic [7:0] ack);
      logic [15:0] c = crc16() ^ flip;
      xb(tok);
      foreach (blk[i]) xb(blk[i]);
      xb(c[15:8]);
      xb(c[7:0]);
      xb(8'hFF);
      check(rx, ack);
      check(wr_blk_crc_ok, flip == 16'h0000);
   endtask : wr_blk

   task automatic rd_blk(input logic fail, input logic [7:0] tok);
      logic [15:0] c = crc16();
      @(negedge mclk) {rd_start, rd_fail, rd_byte, idx} = {1'b1, fail, blk[0], 32'h1};
      @(negedge mclk) {rd_start, rd_byte, idx} = {1'b0, blk[1], 32'h2};
      rx = 8'hFF;
      for (int n = 0; n < 16 && rx === 8'hFF; n++) xb(8'hFF);
      check(rx, tok);
      if (!fail) begin
         foreach (blk[i]) begin
            xb(8'hFF);
            check(rx, blk[i]);
         end
         xb(8'hFF);
         check(rx, c[15:8]);
         xb(8'hFF);
         check(rx, c[7:0]);
      end
   endtask : rd_blk

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop

   initial begin
      #300000 mismatches++;
      report_and_stop();
   end

   initial begin
      {rst_n, rd_start, rd_fail, rd_byte, wr_fail, busy, evt} = '0;
      {reset_cmd, init_done, locked_in, short_rd, long_rd, halt_seen} = '0;
      repeat (5) @(negedge mclk);
      u_host_link_model.idle_clk(5);
      @(negedge mclk) rst_n = 1'b1;
      u_host_link_model.idle_clk(4);
      check(long_resp, 16'h0100);
      flags();
      u_host_link_model.sel(1'b1);
      wr_blk(8'hFE, 16'h0000, 8'hE5);
      check(wr_byte, blk[3]);
      wr_blk(8'hFC, 16'h0100, 8'hEB);
      @(negedge mclk) wr_fail = 1'b1;
      wr_blk(8'hFC, 16'h0000, 8'hED);
      @(negedge mclk) wr_fail = 1'b0;
      xb(8'hFD);
      xb(8'hFF);
      check(halt_seen, 1'b1);
      check({n_wr[7:0], n_blk[7:0]}, 16'h0C03);
      pulse_in(long_rd);
      @(negedge mclk) busy = 1'b1;
      xb(8'hFF);
      xb(8'hFF);
      check(rx, 8'h00);
      @(negedge mclk) busy = 1'b0;
      xb(8'hFF);
      xb(8'hFF);
      check(rx, 8'hFF);
      rd_blk(1'b0, 8'hFE);
      @(negedge mclk) evt.ecc_failed = 1'b1;
      @(negedge mclk) evt = '0;
      rd_blk(1'b1, 8'h04);
      repeat (20) @(negedge mclk);
      check(long_resp, 16'h0000);
      u_host_link_model.sel(1'b0);
      @(negedge mclk) check(miso_oe_n, 1'b1);
      report_and_stop();
   end
endmodule : tb_card_data_link

/* File: logic/card_data_link.sv */
// data-token framing, write acknowledge, read-failure token and status flags
// assumes link_clk, cs_n and mosi come from the host, all else from core logic on mclk
`timescale 1ns/10ps
// Overview of operation
// RL1 - acknowledge every received write block
// RL2 - acknowledge codes 010, 101, 110
// RL3 - host halts multi-write after a failure
// RL4 - host queries status after write failure
// RL5 - every byte moves msb first
// RL6 - start byte, N payload bytes, 16-bit crc
// RL7 - start FE, multi-write FC, halt FD
// RL8 - failed read sends read-failure token instead
// RL9 - token low nibble equals long-status error bits
// RL10 - status in short, long and token carriers
// RL11 - error flags clear when read
// RL12 - locked and idle follow state
// RL13 - idle set at reset, cleared by init
// RL14 - locked reads one while password lock holds
// RL15 - response and execution flags set by events
// RL16 - no underrun or overrun flags
// RL17 - erase-skip on partial protected erase
// RL18 - erase-reset when erase sequence discarded
// RL19 - register-overwrite on illegal register change
// RL20 - command-crc flag on bad command checksum
// RL21 - address-error on misaligned address
// RL22 - zero bytes while busy, ones when ready
// RL23 - check block crc before choosing code
module card_data_link
   import card_pkg::*;
#(
   parameter int BLK_LEN = BLK_LEN_DEF
) (
   // core clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // serial link
   input  wire logic        link_clk,
   input  wire logic        cs_n,
   input  wire logic        mosi,
   output logic             miso_o,
   output logic             miso_oe_n,
   // read data source
   input  wire logic        rd_start,
   input  wire logic        rd_fail,
   input  wire logic [7:0]  rd_byte,
   output logic             rd_byte_req,
   // write data sink
   output logic [7:0]       wr_byte,
   output logic             wr_byte_valid,
   output logic             wr_blk_done,
   output logic             wr_blk_crc_ok,
   output logic             wr_halt,
   input  wire logic        wr_fail,
   input  wire logic        busy,
   // status events and state
   input  flag_evt_s        evt,
   input  wire logic        reset_cmd,
   input  wire logic        init_done,
   input  wire logic        locked_in,
   input  wire logic        short_rd,
   input  wire logic        long_rd,
   output short_resp_s      short_resp,
   output logic [15:0]      long_resp
);

   localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(BLK_LEN - 1);
   localparam logic [CNT_W-1:0] PRE_IDX  = CNT_W'(BLK_LEN - 2);

   if (BLK_LEN < BLK_LEN_MIN || BLK_LEN > BLK_LEN_MAX) begin : g_bad_len
      $error("block length out of range");
   end

   core_s       c_reg;
   core_s       c_next;
   link_s       l_reg;
   link_s       l_next;
   logic [15:0] crc_rx_q;
   logic [15:0] crc_rx_d;
   logic [15:0] crc_tx_q;
   logic [15:0] crc_tx_d;
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic        rd_pend;
   logic [7:0]  idle_byte;
   logic        ack_point;

   assign byte_done = (l_reg.bit_cnt == BIT_LAST);
   assign rx_byte   = {l_reg.rx_sh, mosi};                                 // [RL5]
   assign rd_pend   = (l_reg.i2[LS_RD] != l_reg.rd_seen);
   assign idle_byte = l_reg.i2[LS_BUSY] ? BYTE_BUSY : BYTE_IDLE;           // [RL22]
   assign ack_point = byte_done && !cs_n && (l_reg.st == L_RX_CRC) && (l_reg.cnt != '0);

   // crc over received payload and crc bytes, remainder zero when good
   crc16_serial u_crc_rx (
      .link_clk (link_clk),
      .clr      (l_reg.st == L_IDLE),
      .en       (!cs_n && (l_reg.st == L_RX_DATA || l_reg.st == L_RX_CRC)),
      .din      (mosi),
      .crc_q    (crc_rx_q),
      .crc_d    (crc_rx_d)
   );

   // crc over transmitted payload
   crc16_serial u_crc_tx (
      .link_clk (link_clk),
      .clr      (l_reg.st == L_TX_START),
      .en       (!cs_n && l_reg.st == L_TX_DATA),
      .din      (l_reg.tx[7]),
      .crc_q    (crc_tx_q),
      .crc_d    (crc_tx_d)
   );

   function automatic logic [7:0] ack_byte(input logic crc_ok, input logic wfail);
      logic [2:0] code;
      code = !crc_ok ? ACK_CRC_BAD : (wfail ? ACK_WR_FAIL : ACK_ACCEPT);
      return {ACK_PAD, 1'b0, code, 1'b1};
   endfunction : ack_byte

   // link side, one byte boundary every eight link clocks
   always_comb begin
      l_next         = l_reg;
      l_next.i1      = {wr_fail, busy, c_reg.rd_tgl};
      l_next.i2      = l_reg.i1;
      l_next.rx_sh   = rx_byte[6:0];
      l_next.bit_cnt = l_reg.bit_cnt + 3'h1;
      l_next.tx      = {l_reg.tx[6:0], 1'b1};                              // [RL5]
      if (byte_done) begin
         l_next.tx = idle_byte;                                             // [RL22]
         case (l_reg.st)
            L_IDLE: begin
               if (rd_pend) begin
                  l_next.rd_seen = l_reg.i2[LS_RD];
                  if (c_reg.rd_fail_hold) begin
                     l_next.tx    = fail_token(c_reg.snap);                 // [RL8] [RL9]
                     l_next.st    = L_TX_ERR;
                     l_next.t_tok = !l_reg.t_tok;
                  end else begin
                     l_next.tx = TOK_START;                                 // [RL7]
                     l_next.st = L_TX_START;
                  end
               end else if (rx_byte == TOK_START || rx_byte == TOK_START_MULTI) begin  // [RL7]
                  l_next.st  = L_RX_DATA;
                  l_next.cnt = '0;
               end else if (rx_byte == TOK_HALT) begin
                  l_next.t_halt = !l_reg.t_halt;                            // [RL3]
               end
            end
            L_RX_DATA: begin
               l_next.wr_hold = rx_byte;
               l_next.t_wr    = !l_reg.t_wr;
               if (l_reg.cnt == LAST_IDX) begin                             // [RL6]
                  l_next.st  = L_RX_CRC;
                  l_next.cnt = '0;
               end else begin
                  l_next.cnt = l_reg.cnt + 1'b1;
               end
            end
            L_RX_CRC: begin
               if (l_reg.cnt == '0) begin
                  l_next.cnt = l_reg.cnt + 1'b1;
               end else begin
                  l_next.blk_ok = (crc_rx_d == CRC_INIT);                   // [RL23]
                  l_next.tx     = ack_byte(crc_rx_d == CRC_INIT, l_reg.i2[LS_WFAIL]);  // [RL1] [RL2]
                  l_next.t_blk  = !l_reg.t_blk;
                  l_next.st     = L_TX_ACK;
               end
            end
            L_TX_START: begin
               l_next.tx    = c_reg.rd_hold;
               l_next.cnt   = '0;
               l_next.t_req = !l_reg.t_req;
               l_next.st    = L_TX_DATA;
            end
            L_TX_DATA: begin
               if (l_reg.cnt == LAST_IDX) begin                             // [RL6]
                  l_next.tx  = crc_tx_d[15:8];
                  l_next.cnt = '0;
                  l_next.st  = L_TX_CRC;
               end else begin
                  l_next.tx  = c_reg.rd_hold;
                  l_next.cnt = l_reg.cnt + 1'b1;
                  if (l_reg.cnt < PRE_IDX) begin
                     l_next.t_req = !l_reg.t_req;
                  end
               end
            end
            L_TX_CRC: begin
               if (l_reg.cnt == '0) begin
                  l_next.tx  = crc_tx_q[7:0];
                  l_next.cnt = l_reg.cnt + 1'b1;
               end else begin
                  l_next.st = L_IDLE;
               end
            end
            default: begin
               l_next.st = L_IDLE;
            end
         endcase
      end
      if (cs_n) begin
         l_next.st      = L_IDLE;
         l_next.bit_cnt = '0;
         l_next.tx      = idle_byte;
      end
      if (!l_reg.rst_sy[1]) begin
         l_next    = '0;
         l_next.tx = BYTE_IDLE;
      end
      l_next.rst_sy = {l_reg.rst_sy[0], rst_n};
   end

   always_ff @(posedge link_clk) begin
      l_reg <= l_next;
   end

   assign miso_o    = l_reg.tx[7];
   assign miso_oe_n = cs_n;

   // core side: crossings and status flags
   always_comb begin
      logic [4:0]  edge_v;
      short_resp_s sr_set;
      status_ext_s ext_set;
      logic [7:0]  sr_clr;
      logic [7:0]  ext_clr;
      edge_v  = c_reg.s2 ^ c_reg.s3;
      sr_set  = '0;
      ext_set = '0;
      sr_clr  = '0;
      ext_clr = '0;
      c_next    = c_reg;
      c_next.s1 = {l_reg.t_tok, l_reg.t_req, l_reg.t_halt, l_reg.t_blk, l_reg.t_wr};
      c_next.s2 = c_reg.s1;
      c_next.s3 = c_reg.s2;
      c_next.wr_valid = edge_v[SY_WR];
      c_next.blk_done = edge_v[SY_BLK];
      c_next.halt     = edge_v[SY_HALT];
      c_next.rd_req   = edge_v[SY_REQ];
      if (edge_v[SY_WR]) begin
         c_next.wr_byte = l_reg.wr_hold;
      end
      if (edge_v[SY_BLK]) begin
         c_next.blk_ok = l_reg.blk_ok;
      end
      if (edge_v[SY_REQ]) begin
         c_next.rd_hold = rd_byte;
      end
      if (rd_start) begin
         c_next.rd_tgl       = !c_reg.rd_tgl;
         c_next.rd_fail_hold = rd_fail;
         c_next.snap         = c_reg.ext & FAIL_MASK;                       // [RL9]
         c_next.rd_hold      = rd_byte;
      end
      // event sources; no underrun or overrun flag exists [RL16]
      sr_set.illegal_cmd            = evt.illegal_cmd;                      // [RL15]
      sr_set.cmd_crc_err            = evt.cmd_crc_err;                      // [RL20]
      sr_set.erase_seq_err          = evt.erase_seq_err;
      sr_set.addr_err               = evt.addr_err;                         // [RL21]
      sr_set.param_err              = evt.param_err;
      sr_set.erase_reset            = evt.erase_reset;                      // [RL18]
      ext_set.out_of_range_ovw      = evt.out_of_range | evt.csd_overwrite; // [RL19]
      ext_set.erase_param           = evt.erase_param;
      ext_set.wp_violation          = evt.wp_violation;
      ext_set.ecc_failed            = evt.ecc_failed;
      ext_set.controller_fault_flag = evt.controller_fault_flag;
      ext_set.gen_error             = evt.gen_error;
      ext_set.erase_skip_lock_fail  = evt.erase_skip | evt.lock_fail;       // [RL17]
      // read clears, set wins over clear
      if (short_rd || long_rd) begin
         sr_clr = ~SR_KEEP;                                                 // [RL11]
      end
      if (long_rd) begin
         ext_clr = ~EXT_KEEP;                                               // [RL11]
      end
      if (edge_v[SY_TOK]) begin
         ext_clr = ext_clr | c_reg.snap;                                    // [RL11]
      end
      c_next.sr  = (c_reg.sr & ~sr_clr) | sr_set;
      c_next.ext = (c_reg.ext & ~ext_clr) | ext_set;
      c_next.sr.zero = 1'b0;
      if (reset_cmd) begin
         c_next.sr.idle = 1'b1;                                             // [RL13]
      end else if (init_done) begin
         c_next.sr.idle = 1'b0;                                             // [RL12] [RL13]
      end
      c_next.ext.locked = locked_in;                                        // [RL12] [RL14]
      if (!rst_n) begin
         c_next         = '0;
         c_next.sr.idle = 1'b1;                                             // [RL13]
      end
   end

   always_ff @(posedge mclk) begin
      c_reg <= c_next;
   end

   // three status carriers [RL10]
   assign short_resp    = c_reg.sr;
   assign long_resp     = {c_reg.sr, c_reg.ext};
   assign wr_byte       = c_reg.wr_byte;
   assign wr_byte_valid = c_reg.wr_valid;
   assign wr_blk_done   = c_reg.blk_done;
   assign wr_blk_crc_ok = c_reg.blk_ok;
   assign wr_halt       = c_reg.halt;
   assign rd_byte_req   = c_reg.rd_req;

   a_ack_format: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL2]
      ack_point |=> (l_reg.tx[7:4] == {ACK_PAD, 1'b0}) && l_reg.tx[0]
         && (l_reg.tx[3:1] == ACK_ACCEPT || l_reg.tx[3:1] == ACK_CRC_BAD || l_reg.tx[3:1] == ACK_WR_FAIL))
      else $error("bad acknowledge byte");
   a_ack_follows: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL1]
      ack_point |=> l_reg.st == L_TX_ACK ##1 (l_reg.st == L_TX_ACK || cs_n)[*7])
      else $error("acknowledge byte not sent");
   a_crc_choice: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL23]
      ack_point && (crc_rx_d != CRC_INIT) |=> l_reg.tx[3:1] == ACK_CRC_BAD && !l_reg.blk_ok)
      else $error("bad crc not rejected");
   a_msb_shift: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL5]
      (!cs_n && !byte_done) ##1 !cs_n |-> l_reg.tx[7:1] == $past(l_reg.tx[6:0]))
      else $error("output not shifted msb first");
   a_payload_len: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL6]
      byte_done && !cs_n && l_reg.st == L_RX_DATA && l_reg.cnt == LAST_IDX |=> l_reg.st == L_RX_CRC)
      else $error("payload length wrong");
   a_start_token: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL7]
      byte_done && !cs_n && l_reg.st == L_IDLE && rd_pend && !c_reg.rd_fail_hold |=> l_reg.tx == TOK_START)
      else $error("start byte wrong");
   a_fail_token: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL9]
      byte_done && !cs_n && l_reg.st == L_IDLE && rd_pend && c_reg.rd_fail_hold
      |=> l_reg.tx == fail_token(c_reg.snap) && l_reg.st == L_TX_ERR)
      else $error("read-failure token wrong");
   a_busy_zero: assert property (@(posedge link_clk) disable iff (!l_reg.rst_sy[1])  // [RL22]
      byte_done && !cs_n && l_reg.st == L_IDLE && !rd_pend && l_reg.i2[LS_BUSY] |=> l_reg.tx == BYTE_BUSY)
      else $error("busy byte not zero");
   a_idle_cmd: assert property (@(posedge mclk) disable iff (!rst_n)  // [RL13]
      reset_cmd |=> c_reg.sr.idle ##1 (c_reg.sr.idle || init_done || $past(init_done)))
      else $error("idle not set by reset command");
   a_idle_exit: assert property (@(posedge mclk) disable iff (!rst_n)  // [RL13]
      init_done && !reset_cmd |=> !c_reg.sr.idle)
      else $error("idle not cleared at init done");
   a_lock_track: assert property (@(posedge mclk) disable iff (!rst_n)  // [RL14]
      ##1 1'b1 |-> c_reg.ext.locked == $past(locked_in))
      else $error("locked bit not following");
   a_long_clear: assert property (@(posedge mclk) disable iff (!rst_n)  // [RL11]
      long_rd && evt == '0 && !reset_cmd |=> (c_reg.ext & ~EXT_KEEP) == '0 && (c_reg.sr & ~SR_KEEP) == '0)
      else $error("flags not cleared by read");
   a_set_wins: assert property (@(posedge mclk) disable iff (!rst_n)  // [RL11]
      evt.addr_err && short_rd |=> c_reg.sr.addr_err && long_resp[8 + 5] == 1'b1)
      else $error("event lost under clear");
   a_csd_ovw: assert property (@(posedge mclk) disable iff (!rst_n)  // [RL19]
      evt.csd_overwrite |=> c_reg.ext.out_of_range_ovw)
      else $error("overwrite flag not set");

endmodule : card_data_link

/* File: logic/crc16_serial.sv */
// bit-serial crc over the data bits of one block
// assumes clr is held for at least one edge before the first bit
`timescale 1ns/10ps
module crc16_serial
   import card_pkg::*;
(
   // link clock
   input  wire logic        link_clk,
   // control and data bit
   input  wire logic        clr,
   input  wire logic        en,
   input  wire logic        din,
   // current and next remainder
   output logic [15:0]      crc_q,
   output logic [15:0]      crc_d
);

   crc_s r_reg;
   crc_s r_next;

   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : CRC_INIT);
   endfunction : crc_step

   always_comb begin
      r_next = r_reg;
      if (clr) begin
         r_next.crc = CRC_INIT;
      end else if (en) begin
         r_next.crc = crc_step(r_reg.crc, din);
      end
   end

   always_ff @(posedge link_clk) begin
      r_reg <= r_next;
   end

   assign crc_q = r_reg.crc;
   assign crc_d = r_next.crc;

endmodule : crc16_serial
